// [bla_addr_seq.sv]
// address phase sequencer: device write byte, offset bytes, then device read byte after a restart
`timescale 1ns/1ns
`default_nettype none

module bla_addr_seq (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // request from the addressing logic
  input wire logic i_start,
  input wire bla_pkg::bla_addr_req_t i_req,
  // byte stream to the serial engine
  input wire logic i_ready,
  output bla_pkg::bla_addr_byte_t o_byte
);

  bla_pkg::bla_seq_st_t s;
  bla_pkg::bla_seq_st_t n;

  always_comb
  begin
    n = s;
    // a request during a running sequence waits, so valid never drops mid-byte
    if (i_start)
    begin
      n.pend = 1'b1;
    end
    if (s.out.valid && i_ready)
    begin
      unique case (s.st)
        bla_pkg::SEQ_IDLE:
        begin
          n.st = bla_pkg::SEQ_IDLE;
        end
        bla_pkg::SEQ_DEV_WR:
        begin
          n.st = s.req.two_byte ? bla_pkg::SEQ_OFF_HI : bla_pkg::SEQ_OFF_LO;
          n.out.data = s.req.two_byte ? s.req.off[15:8] : s.req.off[7:0];
          n.out.restart = 1'b0;
          n.out.last = 1'b0;
        end
        bla_pkg::SEQ_OFF_HI:
        begin
          n.st = bla_pkg::SEQ_OFF_LO;
          n.out.data = s.req.off[7:0];
        end
        bla_pkg::SEQ_OFF_LO:
        begin
          n.st = bla_pkg::SEQ_DEV_RD;
          n.out.data = {s.req.dev, 1'b1};
          n.out.restart = 1'b1;
          n.out.last = 1'b1;
        end
        bla_pkg::SEQ_DEV_RD:
        begin
          n.st = bla_pkg::SEQ_IDLE;
          n.out = '0;
        end
      endcase
    end
    if (n.st == bla_pkg::SEQ_IDLE && n.pend)
    begin
      n.pend = 1'b0;
      n.req = i_req;
      n.st = bla_pkg::SEQ_DEV_WR;
      n.out.valid = 1'b1;
      n.out.data = {i_req.dev, 1'b0};
      n.out.restart = 1'b1;
      n.out.last = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s <= bla_pkg::SEQ_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  assign o_byte = s.out;

endmodule : bla_addr_seq

`default_nettype wire

// [bla_boot_addr.sv]
// boot load addressing: control register, strap latch, working device address and offset
//
// Contract
// - boot_device_addr field is the EEPROM device address
// - strap pins fill address bits 1:0 at power-up
// - strap bits change only with latch_bits_unlock written 1
// - working address copied at start or chain
// - boundary field selects 8..1024 bytes or none
// - finite boundary re-addresses only on crossing
// - no boundary still re-addresses on increment, chain
// - boundary field changes act immediately
// - start offset gives upper bits, low three zero
// - offset is start shifted by 3, then increments
// - new start offset plus chain continues there
// - offset_width_sel picks one or two offset bytes
// - page increment bumps address bits on offset wrap
// - chain needs chain_to_next and zero load count
`timescale 1ns/1ns
`default_nettype none

module bla_boot_addr (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register bus, AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [bla_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // register bus, AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [bla_pkg::AXI_AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // board straps
  input wire logic [bla_pkg::STRAP_W-1:0] i_strap_select_pins,
  // rest of the loader
  input wire logic i_boot_start,
  input wire logic i_boot_done,
  input wire logic i_load_count_zero,
  input wire logic i_byte_read,
  output logic o_boot_active,
  output logic [bla_pkg::DEV_W-1:0] o_dev_addr,
  output logic [bla_pkg::OFF_W-1:0] o_offset,
  output logic o_offset_two_byte,
  // address phase byte stream to the serial engine
  output logic o_addr_valid,
  input wire logic i_addr_ready,
  output logic [7:0] o_addr_data,
  output logic o_addr_restart,
  output logic o_addr_last
);

  bla_pkg::bla_main_st_t s;
  bla_pkg::bla_main_st_t n;
  bla_pkg::bla_addr_req_t seq_req;
  bla_pkg::bla_addr_byte_t seq_byte;

  // start offset as the internal offset: one byte uses only five programmed bits
  function automatic logic [bla_pkg::OFF_W-1:0] start_offset(input logic [31:0] c);
    logic [bla_pkg::PSTART_W-1:0] p;
    p = c[bla_pkg::PSTART_LSB +: bla_pkg::PSTART_W];
    if (c[bla_pkg::WIDTH_BIT])
    begin
      return {p, 3'h0};
    end
    return {8'h00, p[4:0], 3'h0};
  endfunction : start_offset

  // byte lanes without a strobe keep the stored value; reserved bits never store
  function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return ((d & m) | (old & ~m)) & bla_pkg::CTRL_WMASK;
  endfunction : merge_write

  // status view: load and sequencer state beside the working copies
  function automatic logic [31:0] status_word(input bla_pkg::bla_main_st_t st, input logic busy);
    logic [31:0] w;
    w = '0;
    w[bla_pkg::STAT_ACTIVE_BIT] = st.active;
    w[bla_pkg::STAT_BUSY_BIT] = busy;
    w[bla_pkg::DEV_LSB +: bla_pkg::DEV_W] = st.dev;
    w[bla_pkg::OFF_W-1:0] = st.off;
    return w;
  endfunction : status_word

  // true when the offset about to be used sits on a finite boundary
  function automatic logic boundary_hit(input logic [bla_pkg::MODE_W-1:0] sel, input logic [bla_pkg::OFF_W-1:0] o);
    if (sel == bla_pkg::MODE_NONE)
    begin
      return 1'b0;
    end
    return (o[10:0] & bla_pkg::boundary_mask(sel)) == 11'h000;
  endfunction : boundary_hit

  always_comb
  begin
    logic [31:0] wr_val;
    logic [bla_pkg::OFF_W-1:0] off_next;
    logic [bla_pkg::MODE_W-1:0] mode;
    logic wr_go;
    logic wrap;
    logic chain;
    wr_val = '0;
    off_next = '0;
    mode = '0;
    wr_go = 1'b0;
    wrap = 1'b0;
    chain = 1'b0;
    n = s;
    n.readdr = 1'b0;

    // strap pins come from the board, so three stages before use
    n.strap_s1 = i_strap_select_pins;
    n.strap_s2 = s.strap_s1;
    n.strap_s3 = s.strap_s2;

    // write channels are taken independently and held until both are in
    if (s.awrdy && i_awvalid)
    begin
      n.aw_hold = 1'b1;
      n.aw_addr = i_awaddr;
    end
    if (s.wrdy && i_wvalid)
    begin
      n.w_hold = 1'b1;
      n.w_data = i_wdata;
      n.w_strb = i_wstrb;
    end
    if (s.bvalid && i_bready)
    begin
      n.bvalid = 1'b0;
    end
    // a response still waiting blocks the next write, so one write is under way
    wr_go = s.aw_hold && s.w_hold && !s.bvalid;
    if (wr_go)
    begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = bla_pkg::RESP_SLVERR;
      if (s.aw_addr == bla_pkg::CTRL_OFFSET)
      begin
        n.bresp = bla_pkg::RESP_OKAY;
        wr_val = merge_write(s.ctrl, s.w_data, s.w_strb);
        // the strap bits keep their latched value unless this very write unlocks them
        if (!(s.w_strb[3] && s.w_data[bla_pkg::UNLK_BIT]))
        begin
          wr_val[bla_pkg::DEV_LSB +: bla_pkg::STRAP_W] = s.ctrl[bla_pkg::DEV_LSB +: bla_pkg::STRAP_W];
        end
        n.ctrl = wr_val;
        // a chain only counts when the write really lands in the control register
        chain = s.active && wr_val[bla_pkg::CHAIN_BIT] && i_load_count_zero;
      end
    end
    n.awrdy = !n.aw_hold;
    n.wrdy = !n.w_hold;

    // read channel: one read at a time, answered the cycle after it is taken
    if (s.rvalid && i_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s.arrdy && i_arvalid)
    begin
      n.rvalid = 1'b1;
      n.rresp = bla_pkg::RESP_OKAY;
      if (i_araddr == bla_pkg::CTRL_OFFSET)
      begin
        n.rdata = s.ctrl;
      end
      else if (i_araddr == bla_pkg::STAT_OFFSET)
      begin
        n.rdata = status_word(s, seq_byte.valid);
      end
      else
      begin
        n.rdata = '0;
        n.rresp = bla_pkg::RESP_SLVERR;
      end
    end
    n.arrdy = !n.rvalid;

    // power-up strap latch, once the last two stages agree; wins over a same-cycle write
    if (!s.strap_done)
    begin
      if (s.strap_cnt != bla_pkg::STRAP_FILL)
      begin
        n.strap_cnt = s.strap_cnt + 2'h1;
      end
      else if (s.strap_s2 == s.strap_s3)
      begin
        n.ctrl[bla_pkg::DEV_LSB +: bla_pkg::STRAP_W] = s.strap_s3;
        n.strap_done = 1'b1;
      end
    end

    // offset advance, boundary and page handling while the load runs
    if (i_boot_done)
    begin
      n.active = 1'b0;
    end
    // boundary field is read live each cycle, so a write acts at once
    mode = s.ctrl[bla_pkg::MODE_LSB +: bla_pkg::MODE_W];
    off_next = s.off + 16'h0001;
    if (!s.two_byte)
    begin
      off_next[15:8] = 8'h00;
    end
    wrap = !s.two_byte && (s.off[7:0] == 8'hFF);
    if (s.active && i_byte_read)
    begin
      n.off = off_next;
      if (wrap && s.inc)
      begin
        // only the working copy moves; the register field keeps its value
        n.dev[2:0] = s.dev[2:0] + 3'h1;
        n.readdr = 1'b1;
      end
      else if (boundary_hit(mode, off_next))
      begin
        n.readdr = 1'b1;
      end
    end

    // boot start or chain: address, offset and their modes are copied in one edge
    if (i_boot_start || chain)
    begin
      n.active = 1'b1;
      n.dev = n.ctrl[bla_pkg::DEV_LSB +: bla_pkg::DEV_W];
      n.off = start_offset(n.ctrl);
      n.two_byte = n.ctrl[bla_pkg::WIDTH_BIT];
      n.inc = n.ctrl[bla_pkg::INC_BIT] && !n.ctrl[bla_pkg::WIDTH_BIT];
      n.readdr = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s <= bla_pkg::MAIN_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  // the sequencer reads the working copies the edge after they were updated
  assign seq_req.dev = s.dev;
  assign seq_req.off = s.off;
  assign seq_req.two_byte = s.two_byte;

  bla_addr_seq u_seq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_start(s.readdr),
    .i_req(seq_req),
    .i_ready(i_addr_ready),
    .o_byte(seq_byte)
  );

  // register bus answers
  assign o_awready = s.awrdy;
  assign o_wready = s.wrdy;
  assign o_bvalid = s.bvalid;
  assign o_bresp = s.bresp;
  assign o_arready = s.arrdy;
  assign o_rvalid = s.rvalid;
  assign o_rdata = s.rdata;
  assign o_rresp = s.rresp;

  // working copies for the rest of the loader
  assign o_boot_active = s.active;
  assign o_dev_addr = s.dev;
  assign o_offset = s.off;
  assign o_offset_two_byte = s.two_byte;

  // address phase stream, registered inside the sequencer
  assign o_addr_valid = seq_byte.valid;
  assign o_addr_data = seq_byte.data;
  assign o_addr_restart = seq_byte.restart;
  assign o_addr_last = seq_byte.last;

endmodule : bla_boot_addr

`default_nettype wire

// [bla_boot_addr_sva.sv]
// checker: address copy and address phase assertions on the block ports
`timescale 1ns/1ns
`default_nettype none
module bla_boot_addr_sva (
  // watched ports
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_boot_start,
  input wire logic i_byte_read,
  input wire logic i_addr_ready,
  input wire logic o_awready,
  input wire logic o_boot_active,
  input wire logic [6:0] o_dev_addr,
  input wire logic [15:0] o_offset,
  input wire logic o_offset_two_byte,
  input wire logic o_addr_valid,
  input wire logic [7:0] o_addr_data,
  input wire logic o_addr_restart,
  input wire logic o_addr_last
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_start; i_boot_start |=> o_boot_active && o_offset[2:0] == 3'h0; endproperty
  property p_launch; $rose(o_boot_active) |-> ##[1:12] o_addr_valid; endproperty
  property p_first; $rose(o_addr_valid) |-> o_addr_restart && o_addr_data == {o_dev_addr, 1'b0}; endproperty
  property p_last; o_addr_valid && o_addr_last |-> o_addr_restart && o_addr_data == {o_dev_addr, 1'b1}; endproperty
  property p_hold; o_addr_valid && !i_addr_ready |=> o_addr_valid && $stable(o_addr_data); endproperty
  property p_msb;
    o_addr_valid && i_addr_ready && o_addr_restart && !o_addr_last && o_offset_two_byte |=> o_addr_data == o_offset[15:8];
  endproperty
  property p_one;
    o_addr_valid && i_addr_ready && o_addr_restart && !o_addr_last && !o_offset_two_byte |=> o_addr_data == o_offset[7:0];
  endproperty
  // write execution cycle has awready low, so a chain is kept out of these two
  // one-byte offsets wrap inside the low byte
  property p_inc; o_boot_active && i_byte_read && !i_boot_start && o_awready |=>
    o_offset == (o_offset_two_byte ? $past(o_offset) + 16'h1 : {8'h00, $past(o_offset[7:0]) + 8'h01});
  endproperty
  property p_keep; o_boot_active && !i_byte_read && !i_boot_start && o_awready |=> $stable(o_dev_addr) && $stable(o_offset);
  endproperty
  a_start: assert property (p_start) else $error("start did not align offset");
  a_launch: assert property (p_launch) else $error("no address phase after start");
  a_first: assert property (p_first) else $error("bad device write byte");
  a_last: assert property (p_last) else $error("bad device read byte");
  a_hold: assert property (p_hold) else $error("address byte dropped");
  a_msb: assert property (p_msb) else $error("high offset byte wrong");
  a_one: assert property (p_one) else $error("one byte offset wrong");
  a_inc: assert property (p_inc) else $error("offset did not advance");
  a_keep: assert property (p_keep) else $error("copies changed");
  c_two: cover property (o_offset_two_byte && $rose(o_addr_valid));
  c_last: cover property (o_addr_valid && o_addr_last && i_addr_ready);
  c_byte: cover property (o_boot_active && i_byte_read);
endmodule : bla_boot_addr_sva
bind bla_boot_addr bla_boot_addr_sva bla_boot_addr_sva_i (.i_core_clk, .i_rst_n, .i_boot_start, .i_byte_read,
  .i_addr_ready, .o_awready, .o_boot_active, .o_dev_addr, .o_offset, .o_offset_two_byte, .o_addr_valid,
  .o_addr_data, .o_addr_restart, .o_addr_last);
`default_nettype wire

// [bla_eeprom_model.sv]
// serial engine and eeprom stand-in: takes address phase bytes, promptly or slowly
`timescale 1ns/1ns
`default_nettype none
module bla_eeprom_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // pacing and stream handshake
  input wire logic i_slow,
  output logic o_ready
);
  logic [1:0] cnt_q;
  // slow mode takes one byte in four cycles, like a stretched serial clock
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 2'h0;
      o_ready <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      o_ready <= !i_slow || cnt_q == 2'h3;
    end
  end
endmodule : bla_eeprom_model
`default_nettype wire

// [bla_pkg.sv]
// package: constants, carrier structs and state types of the boot load addressing block
`default_nettype none
package bla_pkg;

  // register map, byte addresses on the register bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;

  // boot_load_control field positions
  localparam int CHAIN_BIT = 31;
  localparam int WIDTH_BIT = 30;
  localparam int INC_BIT = 29;
  localparam int UNLK_BIT = 28;
  localparam int DEV_LSB = 16;
  localparam int DEV_W = 7;
  localparam int STRAP_W = 2;
  localparam int MODE_LSB = 13;
  localparam int MODE_W = 3;
  localparam int PSTART_LSB = 0;
  localparam int PSTART_W = 13;
  localparam int OFF_W = 16;

  // status register field positions
  localparam int STAT_ACTIVE_BIT = 31;
  localparam int STAT_BUSY_BIT = 30;

  // reset values: inc on, one-byte offsets, mode 000, device address 7'h50 (plain default)
  localparam logic [31:0] CTRL_RESET = 32'h2050_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hF07F_FFFF;
  localparam logic [2:0] MODE_NONE = 3'h7;
  localparam logic [1:0] STRAP_FILL = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_DEV_WR,
    SEQ_OFF_HI,
    SEQ_OFF_LO,
    SEQ_DEV_RD
  } bla_seq_state_t;

  // what the address phases need: working device address, offset and its width
  typedef struct packed {
    logic [DEV_W-1:0] dev;
    logic [OFF_W-1:0] off;
    logic two_byte;
  } bla_addr_req_t;

  // one byte of the address phase stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic restart;
    logic last;
  } bla_addr_byte_t;

  typedef struct packed {
    bla_seq_state_t st;
    logic pend;
    bla_addr_req_t req;
    bla_addr_byte_t out;
  } bla_seq_st_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [STRAP_W-1:0] strap_s3;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic active;
    logic two_byte;
    logic inc;
    logic [DEV_W-1:0] dev;
    logic [OFF_W-1:0] off;
    logic readdr;
    logic awrdy;
    logic aw_hold;
    logic [AXI_AW-1:0] aw_addr;
    logic wrdy;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bla_main_st_t;

  localparam bla_seq_st_t SEQ_RESET = '{st: SEQ_IDLE, pend: 1'b0, req: '0, out: '0};

  localparam bla_main_st_t MAIN_RESET = '{
    ctrl: CTRL_RESET, strap_s1: '0, strap_s2: '0, strap_s3: '0, strap_cnt: '0,
    strap_done: 1'b0, active: 1'b0, two_byte: 1'b0, inc: 1'b0, dev: '0, off: '0,
    readdr: 1'b0, awrdy: 1'b1, aw_hold: 1'b0, aw_addr: '0, wrdy: 1'b1, w_hold: 1'b0,
    w_data: '0, w_strb: '0, bvalid: 1'b0, bresp: '0, arrdy: 1'b1, rvalid: 1'b0,
    rdata: '0, rresp: '0};

  // low offset bits that must be zero right after a boundary is crossed
  function automatic logic [10:0] boundary_mask(input logic [2:0] sel);
    logic [10:0] m;
    m = 11'h7FF;
    case (sel)
      3'h0: m = 11'h007;
      3'h1: m = 11'h01F;
      3'h2: m = 11'h03F;
      3'h3: m = 11'h07F;
      3'h4: m = 11'h0FF;
      3'h5: m = 11'h1FF;
      3'h6: m = 11'h3FF;
      default: m = 11'h7FF;
    endcase
    return m;
  endfunction : boundary_mask

endpackage : bla_pkg

`default_nettype wire

// [tb_top.sv]
// testbench: register, boot, boundary, page and chain tests of the boot load addressing block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, rst_n, awv, wv, brdy, arv, rrdy, start, done, lcz, byte_rd, slow;
  logic awr, wr, bv, arr, rv, act, two, av, ardy, arst, al;
  logic [7:0] awa, ara, ad;
  logic [31:0] wd, rd, rdo;
  logic [1:0] strap, br, rr, rro, wrs;
  logic [6:0] dev;
  logic [15:0] off;
  logic [7:0] bq [$];
  int num_errors, checks_done, nph, p0;
  bla_boot_addr bla_boot_addr_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv),
    .i_bready(brdy), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(rrdy), .o_rdata(rdo), .o_rresp(rro), .i_strap_select_pins(strap), .i_boot_start(start),
    .i_boot_done(done), .i_load_count_zero(lcz), .i_byte_read(byte_rd), .o_boot_active(act),
    .o_dev_addr(dev), .o_offset(off), .o_offset_two_byte(two), .o_addr_valid(av), .i_addr_ready(ardy),
    .o_addr_data(ad), .o_addr_restart(arst), .o_addr_last(al));
  bla_eeprom_model bla_eeprom_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .o_ready(ardy));
  // flop outputs sampled at the falling edge hold the value seen at the next rising edge
  always @(negedge clk)
    if (av && ardy)
    begin
      bq.push_back(ad);
      if (arst && !al) nph++;
    end
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    @(negedge clk);
    checks_done++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, b;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1; n = 0; b = 1'b0;
    while (!b && n < 40)
    begin
      @(negedge clk);
      ta = awv && awr; tw = wv && wr; b = bv; wrs = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      n++;
    end
    brdy <= 1'b0;
    if (!b) begin num_errors++; stop_test(); end
  endtask : axw
  task axr(input logic [7:0] a);
    int n;
    logic ta, r;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1; n = 0; r = 1'b0;
    while (!r && n < 40)
    begin
      @(negedge clk);
      ta = arv && arr; r = rv; rd = rdo; rr = rro;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      n++;
    end
    rrdy <= 1'b0;
    if (!r) begin num_errors++; stop_test(); end
  endtask : axr
  // launch comes one cycle after the causing edge, then wait for the phase to drain
  task settle;
    int k;
    repeat (3) @(posedge clk);
    k = 0;
    do begin @(negedge clk); k++; end while (av && k < 80);
    if (av) begin num_errors++; stop_test(); end
  endtask : settle
  task rdb(input int n);
    @(posedge clk);
    repeat (n) begin byte_rd <= 1'b1; @(posedge clk); end
    byte_rd <= 1'b0;
    settle();
  endtask : rdb
  task boot;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    settle();
  endtask : boot
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial
  begin
    {rst_n, awv, wv, brdy, arv, rrdy, start, done, lcz, byte_rd, slow} = '0;
    awa = '0; ara = '0; wd = '0; strap = 2'h2; num_errors = 0; checks_done = 0; nph = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    axr(8'h00);
    chk("ctrl reset", 32'h2052_0000, rd);
    axw(8'h00, 32'h007D_0000);
    chk("write okay", 32'h0, {30'h0, wrs});
    axr(8'h00);
    chk("locked", 32'h007E_0000, rd & 32'h007F_FFFF);
    axw(8'h00, 32'h107D_0000);
    axr(8'h00);
    chk("unlocked", 32'h007D_0000, rd & 32'h007F_FFFF);
    axr(8'h08);
    chk("unmapped", 32'h2, {30'h0, rr});
    axw(8'h04, 32'hFFFF_FFFF);
    chk("status write", 32'h2, {30'h0, wrs});
    axr(8'h00);
    chk("refused write", 32'h107D_0000, rd);
    $display("test registers done");
    slow <= 1'b1;
    axw(8'h00, 32'h407D_E127);
    boot();
    chk("dev", 32'h7D, {25'h0, dev});
    chk("offset", 32'h0938, {16'h0, off});
    chk("phase", 32'hFA09_38FB, {bq[0], bq[1], bq[2], bq[3]});
    $display("test two byte done");
    slow <= 1'b0;
    for (int m = 0; m < 7; m++)
    begin
      axw(8'h00, {16'h407D, m[2:0], 13'h0});
      boot();
      p0 = nph;
      rdb((8 << (m == 0 ? 0 : m + 1)) - 1);
      chk("early", p0, nph);
      rdb(1);
      chk("cross", p0 + 1, nph);
    end
    $display("test boundaries done");
    axw(8'h00, 32'h207D_E01F);
    boot();
    p0 = nph;
    rdb(7);
    chk("no boundary", p0, nph);
    rdb(1);
    chk("page dev", 32'h7E, {25'h0, dev});
    chk("page phase", p0 + 1, nph);
    axw(8'h00, 32'h207D_001F);
    p0 = nph;
    rdb(8);
    chk("mode now", p0 + 1, nph);
    chk("copy kept", 32'h7E, {25'h0, dev});
    axw(8'h00, 32'h8061_E005);
    chk("no chain", 32'h7E, {25'h0, dev});
    @(posedge clk) lcz <= 1'b1;
    p0 = nph;
    axw(8'h00, 32'h8061_E005);
    settle();
    chk("chain dev", 32'h61, {25'h0, dev});
    chk("chain offset", 32'h28, {16'h0, off});
    chk("chain phase", p0 + 1, nph);
    $display("test chain done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
